// File: src/sma_pkg.sv
// Purpose: shared constants and types of the switch monitor alert control
// Assumes: 24 switch inputs, 6 compare groups, 20 MHz core clock
// Notes:   flag word holds 24 switch bits, then warning and supply bits
package sma_pkg;

    localparam int NUM_IN    = 24;
    localparam int GRP_SIZE  = 4;
    localparam int NUM_GRP   = NUM_IN / GRP_SIZE;
    localparam int FLAG_W    = NUM_IN + 2;
    localparam int TEMP_BIT  = 24;
    localparam int SUPPLY_BIT = 25;
    localparam int LVL_W     = 2;
    localparam int WET_W     = 3;
    localparam int HALF_IN   = NUM_IN / 2;

    // compare level codes
    localparam logic [1:0] LVL_2V0 = 2'h0;
    localparam logic [1:0] LVL_2V7 = 2'h1;
    localparam logic [1:0] LVL_3V0 = 2'h2;
    localparam logic [1:0] LVL_4V0 = 2'h3;

    // drive current codes, others fall back to zero current
    localparam logic [2:0] WET_0MA  = 3'h0;
    localparam logic [2:0] WET_1MA  = 3'h1;
    localparam logic [2:0] WET_2MA  = 3'h2;
    localparam logic [2:0] WET_5MA  = 3'h3;
    localparam logic [2:0] WET_10MA = 3'h4;
    localparam logic [2:0] WET_15MA = 3'h5;
    localparam logic [2:0] WET_RST  = WET_0MA;

    // scheme select values
    localparam logic SCHEME_STATIC  = 1'b0;
    localparam logic SCHEME_DYNAMIC = 1'b1;

    // interval lengths in core clock cycles
    localparam int CNT_W               = 12;
    localparam int ALERT_LOW_CYCLES    = 200;
    localparam int ALERT_HIGH_INTERVAL = 200;
    localparam int IDLE_HOLD_CYCLES    = 40;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STATIC_LOW,
        ST_DYN_LOW,
        ST_DYN_HIGH,
        ST_HOLDOFF
    } sma_alert_state_type;

    typedef struct packed {
        logic [1:0]                  frm_s;
        logic                        frm_d;
        logic [1:0]                  rd_s;
        logic                        rd_d;
        logic [1:0]                  line_s;
        logic                        scheme;
        logic [FLAG_W-1:0]           flags;
        logic [FLAG_W-1:0]           snap;
        logic [NUM_IN-1:0]           prev_lvl;
        logic                        base_ok;
        sma_alert_state_type         st;
        logic [CNT_W-1:0]            cnt;
        logic                        alert_o;
        logic                        alert_oe_n;
        logic [NUM_IN*LVL_W-1:0]     thr;
        logic [NUM_IN*WET_W-1:0]     wet;
        logic                        wake_ok;
    } sma_core_type;

    typedef struct packed {
        logic frame_open;
        logic read_done;
    } sma_link_type;

endpackage : sma_pkg

// File: src/sma_cross_if.sv
// Purpose: levels handed from the link clock side to the core side
// Assumes: both levels are cleared while chip select is high
// Notes:   the core side synchronises each level with two flip-flops
`timescale 1ns/10ps
interface sma_cross_if;
    logic frame_open;
    logic flag_read_done;

    modport link
    (
        output frame_open,
        output flag_read_done
    );
    modport core
    (
        input frame_open,
        input flag_read_done
    );
endinterface : sma_cross_if

// File: src/sma_link_mon.sv
// Purpose: marks frame start and flag register reads on the serial clock
// Assumes: spi_flag_read comes from decode logic on spi_sclk
// Notes:   chip select high clears both levels, so no frame-end edge is needed
`timescale 1ns/10ps
module sma_link_mon
(
    input  wire logic spi_sclk,
    input  wire logic spi_cs_n,
    input  wire logic spi_flag_read,
    sma_cross_if.link xo
);
    import sma_pkg::*;

    sma_link_type link_reg;
    sma_link_type link_next;

    always_comb
    begin
        link_next = link_reg;
        link_next.frame_open = 1'b1;
        if (spi_flag_read)
        begin
            link_next.read_done = 1'b1;
        end
    end

    // serial clock may stop outside frames; chip select is the only clean reset
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            link_reg <= '0;
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    assign xo.frame_open     = link_reg.frame_open;
    assign xo.flag_read_done = link_reg.read_done;

    a_read_in_frame: assert property (@(posedge spi_sclk) disable iff (spi_cs_n)
        link_reg.read_done |-> link_reg.frame_open)
        else $error("read seen outside an open frame");

endmodule : sma_link_mon

// File: src/sma_alert_ctrl.sv
// Purpose: alert line, event flags and configuration fields of a switch monitor
// Assumes: switch levels and events arrive on the core clock
// Notes:   alert pin is open drain; enable low means the pin is pulled low
//
// What this block does
// - one compare level code is shared by each group of four adjacent inputs
// - the compare level code picks 2 V, 2.7 V, 3 V or 4 V
// - drive current codes give 0, 1, 2, 5, 10 or 15 mA
// - every drive current selection is zero current after reset
// - alert is active low open drain, pulled low on any event
// - scheme bit 0 selects static alert, 1 selects pulsing alert
// - static alert stays low until a frame reading the flags ends
// - flags are snapshot at first serial edge, cleared when a read hits them
// - pulsing alert stays low one active interval, then high if unread
// - pulsing alert keeps alternating low and high until the flags are read
// - read during low phase releases alert and clears flags at frame end
// - read during high phase clears flags and stops pulsing
// - static scheme after reset; scheme changes only while stopped
// - reading pending unmasked flags starts a hold-off with alert released
// - events during hold-off set flags at once, alert waits for hold-off end
// - a second read during hold-off clears flags, no alert afterwards
// - wake-up through the regulator path only in static scheme
// - flag word has a supply high bit set on entering or leaving
// - per-input enables choose rising, falling or both edge events
`timescale 1ns/10ps
module sma_alert_ctrl
(
    input  wire logic                                    clock,
    input  wire logic                                    nrst,
    input  wire logic                                    clk_en,
    input  wire logic                                    spi_sclk,
    input  wire logic                                    spi_cs_n,
    input  wire logic                                    spi_flag_read,
    input  wire logic                                    cfg_run,
    input  wire logic                                    cfg_scheme,
    input  wire logic [sma_pkg::NUM_GRP*sma_pkg::LVL_W-1:0] compare_level_cfg,
    input  wire logic [sma_pkg::HALF_IN*sma_pkg::WET_W-1:0] drive_current_cfg0,
    input  wire logic [sma_pkg::HALF_IN*sma_pkg::WET_W-1:0] drive_current_cfg1,
    input  wire logic [2*sma_pkg::NUM_IN-1:0]            edge_irq_enable_cfg,
    input  wire logic                                    sample_valid,
    input  wire logic [sma_pkg::NUM_IN-1:0]              sample_level,
    input  wire logic                                    temp_warn_evt,
    input  wire logic                                    supply_high_evt,
    input  wire logic                                    alert_n_i,
    output logic                                         alert_n_o,
    output logic                                         alert_n_oe,
    output logic                                         alert_line_low,
    output logic [sma_pkg::FLAG_W-1:0]                   event_flags,
    output logic [sma_pkg::FLAG_W-1:0]                   flag_snapshot,
    output logic [sma_pkg::NUM_IN*sma_pkg::LVL_W-1:0]    input_level_code,
    output logic [sma_pkg::NUM_IN*sma_pkg::WET_W-1:0]    input_wet_code,
    output logic                                         scheme_active,
    output logic                                         wake_capable
);
    import sma_pkg::*;

    localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(ALERT_LOW_CYCLES - 1);
    localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(ALERT_HIGH_INTERVAL - 1);
    localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_HOLD_CYCLES - 1);

    sma_core_type              core_reg;
    sma_core_type              core_next;
    logic [FLAG_W-1:0]         new_evt;
    logic [NUM_IN*LVL_W-1:0]   thr_cfg;
    logic [NUM_IN*WET_W-1:0]   wet_cfg;
    logic                      frame_start;
    logic                      read_commit;

    sma_cross_if xc ();

    sma_link_mon u_link
    (
        .spi_sclk      (spi_sclk),
        .spi_cs_n      (spi_cs_n),
        .spi_flag_read (spi_flag_read),
        .xo            (xc.link)
    );

    // ********************************************************
    // per-input event detection and configuration fields
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi = gi + 1)
        begin : g_in
            logic [WET_W-1:0] raw_wet;
            logic             rise;
            logic             fall;
            assign rise = sample_level[gi] & ~core_reg.prev_lvl[gi];
            assign fall = ~sample_level[gi] & core_reg.prev_lvl[gi];
            // first sample only sets the baseline
            assign new_evt[gi] = sample_valid & core_reg.base_ok
                               & ((rise & edge_irq_enable_cfg[2*gi])
                               | (fall & edge_irq_enable_cfg[2*gi+1]));
            assign thr_cfg[gi*LVL_W +: LVL_W] =
                compare_level_cfg[(gi/GRP_SIZE)*LVL_W +: LVL_W];
            if (gi < HALF_IN)
            begin : g_lo
                assign raw_wet = drive_current_cfg0[gi*WET_W +: WET_W];
            end
            else
            begin : g_hi
                assign raw_wet = drive_current_cfg1[(gi-HALF_IN)*WET_W +: WET_W];
            end
            // codes above fifteen milliamps are not defined, treat as off
            assign wet_cfg[gi*WET_W +: WET_W] = (raw_wet <= WET_15MA) ? raw_wet : WET_0MA;
        end
    endgenerate

    assign new_evt[TEMP_BIT]   = temp_warn_evt;
    assign new_evt[SUPPLY_BIT] = supply_high_evt;

    // edges taken from second synchroniser stage only
    assign frame_start = core_reg.frm_s[1] & ~core_reg.frm_d;
    assign read_commit = core_reg.rd_d & ~core_reg.rd_s[1];

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        core_next = core_reg;
        core_next.frm_s  = {core_reg.frm_s[0], xc.frame_open};
        core_next.frm_d  = core_reg.frm_s[1];
        core_next.rd_s   = {core_reg.rd_s[0], xc.flag_read_done};
        core_next.rd_d   = core_reg.rd_s[1];
        core_next.line_s = {core_reg.line_s[0], ~alert_n_i};

        if (sample_valid)
        begin
            core_next.prev_lvl = sample_level;
            core_next.base_ok  = 1'b1;
        end

        if (!cfg_run)
        begin
            core_next.scheme = cfg_scheme;
            core_next.thr    = thr_cfg;
            core_next.wet    = wet_cfg;
        end
        core_next.wake_ok = (core_reg.scheme == SCHEME_STATIC);

        if (frame_start)
        begin
            core_next.snap = core_reg.flags;
        end

        // only snapshot bits are cleared; a fresh event always survives
        if (read_commit)
        begin
            core_next.flags = (core_reg.flags & ~core_reg.snap) | new_evt;
        end
        else
        begin
            core_next.flags = core_reg.flags | new_evt;
        end

        if (read_commit && core_reg.snap != '0)
        begin
            core_next.st         = ST_HOLDOFF;
            core_next.cnt        = '0;
            core_next.alert_oe_n = 1'b1;
        end
        else
        begin
            unique case (core_reg.st)
                ST_IDLE:
                begin
                    if (core_reg.flags != '0)
                    begin
                        core_next.alert_oe_n = 1'b0;
                        core_next.cnt        = '0;
                        core_next.st         = (core_reg.scheme == SCHEME_DYNAMIC)
                                             ? ST_DYN_LOW : ST_STATIC_LOW;
                    end
                end
                ST_STATIC_LOW:
                begin
                    core_next.alert_oe_n = 1'b0;
                end
                ST_DYN_LOW:
                begin
                    if (core_reg.cnt == LOW_LAST)
                    begin
                        core_next.st         = ST_DYN_HIGH;
                        core_next.alert_oe_n = 1'b1;
                        core_next.cnt        = '0;
                    end
                    else
                    begin
                        core_next.cnt = core_reg.cnt + 1'b1;
                    end
                end
                ST_DYN_HIGH:
                begin
                    if (core_reg.cnt == HIGH_LAST)
                    begin
                        core_next.st         = ST_DYN_LOW;
                        core_next.alert_oe_n = 1'b0;
                        core_next.cnt        = '0;
                    end
                    else
                    begin
                        core_next.cnt = core_reg.cnt + 1'b1;
                    end
                end
                ST_HOLDOFF:
                begin
                    // idle re-checks flags, so a second read leaves nothing to raise
                    if (core_reg.cnt == IDLE_LAST)
                    begin
                        core_next.st  = ST_IDLE;
                        core_next.cnt = '0;
                    end
                    else
                    begin
                        core_next.cnt = core_reg.cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            core_reg            <= '0;
            core_reg.scheme     <= SCHEME_STATIC;
            core_reg.alert_oe_n <= 1'b1;
            core_reg.wake_ok    <= 1'b1;
            core_reg.wet        <= {NUM_IN{WET_RST}};
        end
        else if (clk_en)
        begin
            core_reg <= core_next;
        end
    end

    assign alert_n_o        = core_reg.alert_o;
    assign alert_n_oe       = core_reg.alert_oe_n;
    assign alert_line_low   = core_reg.line_s[1];
    assign event_flags      = core_reg.flags;
    assign flag_snapshot    = core_reg.snap;
    assign input_level_code = core_reg.thr;
    assign input_wet_code   = core_reg.wet;
    assign scheme_active    = core_reg.scheme;
    assign wake_capable     = core_reg.wake_ok;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_static_stays_low: assert property (
        clk_en && core_reg.st == ST_STATIC_LOW && !read_commit |=> !alert_n_oe)
        else $error("static alert released without flag read");

    a_read_releases: assert property (
        clk_en && read_commit && core_reg.snap != '0 |=> alert_n_oe && core_reg.st == ST_HOLDOFF)
        else $error("flag read did not release alert");

    a_low_phase_end: assert property (
        clk_en && core_reg.st == ST_DYN_LOW && core_reg.cnt == LOW_LAST && !read_commit
        |=> alert_n_oe && core_reg.st == ST_DYN_HIGH)
        else $error("active interval did not end high");

    a_high_phase_end: assert property (
        clk_en && core_reg.st == ST_DYN_HIGH && core_reg.cnt == HIGH_LAST && !read_commit
        |=> !alert_n_oe)
        else $error("alert not re-asserted after inactive interval");

    a_high_read_stops: assert property (
        clk_en && core_reg.st == ST_DYN_HIGH && read_commit && core_reg.snap != '0
        |=> alert_n_oe [*8])
        else $error("pulsing resumed after read in high phase");

    a_holdoff_quiet: assert property (
        core_reg.st == ST_HOLDOFF |-> alert_n_oe && core_reg.cnt <= IDLE_LAST)
        else $error("alert asserted during hold-off");

    a_event_kept: assert property (
        clk_en && new_evt != '0 |=> (event_flags & $past(new_evt)) == $past(new_evt))
        else $error("event lost from flag register");

    a_snapshot_taken: assert property (
        clk_en && frame_start |=> flag_snapshot == $past(event_flags))
        else $error("flags not snapshot at frame start");

    a_scheme_locked: assert property (
        clk_en && cfg_run |=> $stable(scheme_active))
        else $error("scheme changed while running");

    a_wake_static: assert property (
        clk_en |=> wake_capable == ($past(scheme_active) == SCHEME_STATIC))
        else $error("wake flag does not follow scheme");

endmodule : sma_alert_ctrl

// File: dv/sma_host_model.sv
// Purpose: host side of the serial link, with its regulator hold line
// Assumes: serial clock of 30 ns that runs only inside frames
// Notes:   flag read decode is offered as a level on the serial clock
`timescale 1ns/10ps
module sma_host_model
(
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_flag_read,
    output logic host_regulator_hold
);
    // ****************************************
    // frame generator
    // ****************************************
    initial
    begin
        spi_sclk            = 1'b0;
        spi_cs_n            = 1'b1;
        spi_flag_read       = 1'b0;
        host_regulator_hold = 1'b0;
    end

    // four serial clocks; rd puts the flag read under the third rising edge
    task automatic frame(input logic rd);
        int k;
        host_regulator_hold = 1'b1;
        #7 spi_cs_n = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            #15 spi_sclk = 1'b1;
            #15 spi_sclk = 1'b0;
            spi_flag_read = rd && (k == 1);
        end
        spi_flag_read = 1'b0;
        #15 spi_cs_n = 1'b1;
        // clock stays still; gap covers edge detect and commit on the core side
        #300;
    endtask : frame
endmodule : sma_host_model

// File: dv/tb_switch_monitor_alert_control.sv
// Purpose: self-checking bench of the alert control block
// Assumes: interval counts as set in the package
// Notes:   alert wire has a pull-up, so a released pin reads high
`timescale 1ns/10ps
module tb_switch_monitor_alert_control import sma_pkg::*;
;
    logic        clock, nrst, cfg_run, cfg_scheme, sample_valid, temp_warn_evt, supply_high_evt, clk_en;
    logic        spi_sclk, spi_cs_n, spi_flag_read, host_hold, alert_wire;
    logic        alert_n_o, alert_n_oe, alert_line_low, scheme_active, wake_capable;
    logic [11:0] compare_level_cfg;
    logic [35:0] drive_current_cfg0, drive_current_cfg1;
    logic [47:0] edge_irq_enable_cfg, input_level_code;
    logic [23:0] sample_level;
    logic [25:0] event_flags, flag_snapshot;
    logic [71:0] input_wet_code;
    int          fails, checks_done, cycles;

    assign alert_wire = alert_n_oe ? 1'b1 : alert_n_o;

    sma_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_flag_read(spi_flag_read),
        .host_regulator_hold(host_hold));

    sma_alert_ctrl DUT (.clock(clock), .nrst(nrst), .clk_en(clk_en), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_flag_read(spi_flag_read), .cfg_run(cfg_run), .cfg_scheme(cfg_scheme),
        .compare_level_cfg(compare_level_cfg), .drive_current_cfg0(drive_current_cfg0),
        .drive_current_cfg1(drive_current_cfg1), .edge_irq_enable_cfg(edge_irq_enable_cfg),
        .sample_valid(sample_valid), .sample_level(sample_level), .temp_warn_evt(temp_warn_evt),
        .supply_high_evt(supply_high_evt), .alert_n_i(alert_wire), .alert_n_o(alert_n_o),
        .alert_n_oe(alert_n_oe), .alert_line_low(alert_line_low), .event_flags(event_flags),
        .flag_snapshot(flag_snapshot), .input_level_code(input_level_code),
        .input_wet_code(input_wet_code), .scheme_active(scheme_active), .wake_capable(wake_capable));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic ev(input logic [2:0] which, input logic [23:0] lvl);
        @(negedge clock);
        sample_level = lvl;
        {supply_high_evt, temp_warn_evt, sample_valid} = which;
        @(negedge clock);
        {supply_high_evt, temp_warn_evt, sample_valid} = 3'h0;
        @(negedge clock);
    endtask : ev

    task automatic hold_oe(input string what, input logic v, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n)
        begin
            @(negedge clock);
            if (alert_n_oe !== v)
                ok = 1'b0;
        end
        chk(what, ok, 1'b1);
    endtask : hold_oe

    task automatic wait_oe(input string what, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && alert_n_oe !== v; n++)
            @(negedge clock);
        chk(what, alert_n_oe, v);
    endtask : wait_oe

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk("oe", alert_n_oe, 1'b1);
        chk("pin drive", alert_n_o, 1'b0);
        chk("flags", event_flags, 26'h0);
        chk("scheme", scheme_active, 1'b0);
        chk("wake", wake_capable, 1'b1);
        chk("wet", input_wet_code, 72'h0);
    endtask : t_reset

    task automatic t_config;
        int i;
        int c;
        @(negedge clock);
        compare_level_cfg = 12'hE4D;
        for (i = 0; i < 12; i++)
        begin
            drive_current_cfg0[3*i+:3] = 3'(i % 8);
            drive_current_cfg1[3*i+:3] = 3'((i + 3) % 8);
        end
        repeat (3) @(negedge clock);
        for (i = 0; i < 24; i++)
        begin
            c = (i < 12) ? i % 8 : (i - 9) % 8;
            chk("level", input_level_code[2*i+:2], compare_level_cfg[2*(i/4)+:2]);
            chk("wet", input_wet_code[3*i+:3], (c < 6) ? 3'(c) : 3'h0);
        end
    endtask : t_config

    task automatic t_static;
        ev(3'h1, 24'h0);
        ev(3'h1, 24'h21);
        chk("flags", event_flags, 26'h1);
        @(negedge clock);
        chk("oe", alert_n_oe, 1'b0);
        ev(3'h4, 24'h21);
        ev(3'h2, 24'h21);
        chk("flags", event_flags, 26'h3000001);
        hold_oe("static low", 1'b0, 100);
        chk("line", alert_line_low, 1'b1);
        host.frame(1'b0);
        chk("hold", host_hold, 1'b1);
        chk("oe", alert_n_oe, 1'b0);
        chk("snap", flag_snapshot, 26'h3000001);
        host.frame(1'b1);
        chk("flags", event_flags, 26'h0);
        chk("oe", alert_n_oe, 1'b1);
        ev(3'h1, 24'h23);
        chk("flags", event_flags, 26'h2);
        hold_oe("holdoff", 1'b1, 15);
        wait_oe("after holdoff", 1'b0, 40);
        host.frame(1'b1);
        ev(3'h1, 24'h27);
        chk("flags", event_flags, 26'h4);
        host.frame(1'b1);
        chk("flags", event_flags, 26'h0);
        hold_oe("no reassert", 1'b1, 100);
    endtask : t_static

    // frozen core ignores a sample; then a falling edge on input 0 counts
    task automatic t_freeze;
        @(negedge clock);
        clk_en = 1'b0;
        edge_irq_enable_cfg[1] = 1'b1;
        ev(3'h1, 24'h2E);
        chk("frozen flags", event_flags, 26'h0);
        chk("frozen oe", alert_n_oe, 1'b1);
        clk_en = 1'b1;
        ev(3'h1, 24'h2E);
        chk("flags", event_flags, 26'h9);
        chk("oe", alert_n_oe, 1'b0);
        host.frame(1'b1);
        chk("flags", event_flags, 26'h0);
        hold_oe("freeze clear", 1'b1, 50);
    endtask : t_freeze

    task automatic t_dynamic;
        @(negedge clock);
        cfg_run = 1'b0;
        cfg_scheme = 1'b1;
        repeat (3) @(negedge clock);
        chk("scheme", scheme_active, 1'b1);
        chk("wake", wake_capable, 1'b0);
        cfg_run = 1'b1;
        cfg_scheme = 1'b0;
        repeat (3) @(negedge clock);
        chk("scheme", scheme_active, 1'b1);
        ev(3'h1, 24'h2F);
        wait_oe("pulse low", 1'b0, 5);
        hold_oe("active", 1'b0, ALERT_LOW_CYCLES - 10);
        wait_oe("release", 1'b1, 20);
        hold_oe("inactive", 1'b1, ALERT_HIGH_INTERVAL - 10);
        wait_oe("reassert", 1'b0, 20);
        host.frame(1'b1);
        chk("oe", alert_n_oe, 1'b1);
        chk("flags", event_flags, 26'h0);
        hold_oe("stay high", 1'b1, 300);
        ev(3'h1, 24'h3F);
        wait_oe("pulse low", 1'b0, 5);
        wait_oe("high phase", 1'b1, ALERT_LOW_CYCLES + 20);
        host.frame(1'b1);
        chk("flags", event_flags, 26'h0);
        hold_oe("pulsing stops", 1'b1, 500);
    endtask : t_dynamic

    // ****************************************
    // clock, timeout and main sequence
    // ****************************************
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // whole run needs about 1800 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end

    initial
    begin
        {nrst, cfg_run, cfg_scheme, sample_valid, temp_warn_evt, supply_high_evt} = 6'h0;
        clk_en = 1'b1;
        {compare_level_cfg, drive_current_cfg0, drive_current_cfg1, sample_level} = '0;
        edge_irq_enable_cfg = {24{2'h1}} & ~(48'h3 << 10);
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
        t_reset();
        t_config();
        cfg_run = 1'b1;
        t_static();
        t_freeze();
        t_dynamic();
        report_and_stop();
    end
endmodule : tb_switch_monitor_alert_control
